// ==== ieb_pkg.sv ====
// constants and shared types of the interrupt enable bank
package ieb_pkg;
   localparam int NWORD = 3;
   localparam int DW = 16;
   localparam int NSTS = 4;
   typedef logic [NWORD-1:0][DW-1:0] ieb_words_t;

   // word index 0..2 holds enable words 1..3
   localparam int W1 = 0;
   localparam int W2 = 1;
   localparam int W3 = 2;

   // byte offsets on the bus
   localparam logic [7:0] OFS_EN1 = 8'h00;
   localparam logic [7:0] OFS_EN2 = 8'h04;
   localparam logic [7:0] OFS_EN3 = 8'h08;
   localparam logic [7:0] OFS_STS = 8'h0c;
   localparam logic [7:0] OFS_MSK = 8'h10;

   // implemented bits per word; all others read zero
   localparam ieb_words_t IMPL_MASK = {16'hbfff, 16'hdfff, 16'h000b};
   localparam logic [DW-1:0] EN_RST = 16'h0000;
   localparam logic [NSTS-1:0] STS_RST = 4'h0;
   localparam logic [NSTS-1:0] MSK_RST = 4'h0;
   localparam int STS_UNMAPPED = 3;

   // enable word 1
   localparam int POS_PIN_CHANGE_IRQ_EN = 3;
   localparam int POS_I2C1_MASTER_IRQ_EN = 1;
   localparam int POS_I2C1_SLAVE_IRQ_EN = 0;
   // enable word 2
   localparam int POS_TIMER6_IRQ_EN = 15;
   localparam int POS_DMA_CH4_DONE_IRQ_EN = 14;
   localparam int POS_COMPARE8_IRQ_EN = 12;
   localparam int POS_COMPARE5_IRQ_EN = 9;
   localparam int POS_CAPTURE6_IRQ_EN = 8;
   localparam int POS_CAPTURE3_IRQ_EN = 5;
   localparam int POS_DMA_CH3_DONE_IRQ_EN = 4;
   localparam int POS_CAN1_EVENT_IRQ_EN = 3;
   localparam int POS_CAN1_RX_READY_IRQ_EN = 2;
   localparam int POS_SPI2_EVENT_IRQ_EN = 1;
   localparam int POS_SPI2_ERROR_IRQ_EN = 0;
   // enable word 3
   localparam int POS_PWM_FAULT_A_IRQ_EN = 15;
   localparam int POS_DMA_CH5_DONE_IRQ_EN = 13;
   localparam int POS_CODEC_IF_EVENT_IRQ_EN = 12;
   localparam int POS_CODEC_IF_ERROR_IRQ_EN = 11;
   localparam int POS_QUAD_ENCODER_IRQ_EN = 10;
   localparam int POS_PWM_ERROR_IRQ_EN = 9;
   localparam int POS_CAN2_EVENT_IRQ_EN = 8;
   localparam int POS_CAN2_RX_READY_IRQ_EN = 7;
   localparam int POS_EXT_PIN4_IRQ_EN = 6;
   localparam int POS_EXT_PIN3_IRQ_EN = 5;
   localparam int POS_TIMER9_IRQ_EN = 4;
   localparam int POS_TIMER8_IRQ_EN = 3;
   localparam int POS_I2C2_MASTER_IRQ_EN = 2;
   localparam int POS_I2C2_SLAVE_IRQ_EN = 1;
   localparam int POS_TIMER7_IRQ_EN = 0;
endpackage

// ==== ieb_gate_if.sv ====
// carrier between the register bank and the gating array
`timescale 1ns/10ps
`default_nettype none
interface ieb_gate_if;
   ieb_pkg::ieb_words_t en;
   ieb_pkg::ieb_words_t req;
   ieb_pkg::ieb_words_t gated;
   modport bank (output en, output req, input gated);
   modport gate (input en, input req, output gated);
endinterface
`default_nettype wire

// ==== ieb_gate_array.sv ====
// per-bit gating of source requests by their enable bits
`timescale 1ns/10ps
`default_nettype none
module ieb_gate_array (
   ieb_gate_if.gate g
);
   genvar w, b;
   generate
      for (w = 0; w < ieb_pkg::NWORD; w++) begin : g_word
         for (b = 0; b < ieb_pkg::DW; b++) begin : g_bit
            // unimplemented positions never pass
            assign g.gated[w][b] = g.req[w][b] & g.en[w][b] & ieb_pkg::IMPL_MASK[w][b];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== ieb_top.sv ====
// interrupt enable bank with classic wishbone register access
// Overview of operation
// - an enable bit of one passes its source request; zero blocks it.
// - word 1 bits 15..4 and 2, word 2 bit 13, word 3 bit 14 always read zero.
// - word 2 bits 15, 14, 12..9 gate timer 6, dma 4, compare 8..5.
// - word 2 bits 8..0 gate capture 6..3, dma 3, can1, spi2 event/error.
// - word 3 bits 15, 13..8 gate pwm fault, dma 5, codec, encoder, pwm, can2.
// - word 3 bits 7..0 gate can2 rx, ext pins, timers 9/8, i2c2, timer 7.
// - word 1 bits 3, 1, 0 gate pin change, i2c1 master, i2c1 slave.
// - word 3 bits 2, 1, 0 gate i2c2 master, i2c2 slave, timer 7.
`timescale 1ns/10ps
`default_nettype none
module ieb_top (
   input wire logic mclk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // source requests, same clock domain
   input wire logic pin_change_req_i,
   input wire logic i2c1_master_req_i,
   input wire logic i2c1_slave_req_i,
   input wire logic timer6_req_i,
   input wire logic dma_ch4_done_req_i,
   input wire logic [3:0] compare8_5_req_i,
   input wire logic [3:0] capture6_3_req_i,
   input wire logic dma_ch3_done_req_i,
   input wire logic can1_event_req_i,
   input wire logic can1_rx_ready_req_i,
   input wire logic spi2_event_req_i,
   input wire logic spi2_error_req_i,
   input wire logic pwm_fault_a_req_i,
   input wire logic dma_ch5_done_req_i,
   input wire logic codec_if_event_req_i,
   input wire logic codec_if_error_req_i,
   input wire logic quad_encoder_req_i,
   input wire logic pwm_error_req_i,
   input wire logic can2_event_req_i,
   input wire logic can2_rx_ready_req_i,
   input wire logic ext_pin4_req_i,
   input wire logic ext_pin3_req_i,
   input wire logic timer9_req_i,
   input wire logic timer8_req_i,
   input wire logic i2c2_master_req_i,
   input wire logic i2c2_slave_req_i,
   input wire logic timer7_req_i,
   // gated requests toward the priority logic
   output logic [15:0] gated_word_1_o,
   output logic [15:0] gated_word_2_o,
   output logic [15:0] gated_word_3_o
);
   typedef struct packed {
      ieb_pkg::ieb_words_t en;
      ieb_pkg::ieb_words_t gated;
      logic [ieb_pkg::NWORD-1:0] any;
      logic [ieb_pkg::NSTS-1:0] sts;
      logic [ieb_pkg::NSTS-1:0] msk;
      logic ack;
      logic [31:0] dat;
      logic irq;
   } ieb_top_state_t;

   ieb_top_state_t s_reg;
   ieb_top_state_t s_next;
   ieb_pkg::ieb_words_t req_words;
   ieb_gate_if gbus ();

   ieb_gate_array u_gate (
      .g(gbus.gate)
   );

   assign gbus.en = s_reg.en;
   assign gbus.req = req_words;

   // byte-lane merge, then strip unimplemented bits
   function automatic logic [15:0] ieb_merge(
      input logic [15:0] old_v,
      input logic [31:0] wdat,
      input logic [3:0] sel,
      input logic [15:0] impl
   );
      logic [15:0] v;
      v = old_v;
      if (sel[0]) begin
         v[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
         v[15:8] = wdat[15:8];
      end
      return v & impl;
   endfunction

   // place each source at its enable position
   always_comb begin
      req_words = '0;
      req_words[ieb_pkg::W1][ieb_pkg::POS_PIN_CHANGE_IRQ_EN] = pin_change_req_i;
      req_words[ieb_pkg::W1][ieb_pkg::POS_I2C1_MASTER_IRQ_EN] = i2c1_master_req_i;
      req_words[ieb_pkg::W1][ieb_pkg::POS_I2C1_SLAVE_IRQ_EN] = i2c1_slave_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_TIMER6_IRQ_EN] = timer6_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_DMA_CH4_DONE_IRQ_EN] = dma_ch4_done_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_COMPARE8_IRQ_EN -: 4] = compare8_5_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_CAPTURE6_IRQ_EN -: 4] = capture6_3_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_DMA_CH3_DONE_IRQ_EN] = dma_ch3_done_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_CAN1_EVENT_IRQ_EN] = can1_event_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_CAN1_RX_READY_IRQ_EN] = can1_rx_ready_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_SPI2_EVENT_IRQ_EN] = spi2_event_req_i;
      req_words[ieb_pkg::W2][ieb_pkg::POS_SPI2_ERROR_IRQ_EN] = spi2_error_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_PWM_FAULT_A_IRQ_EN] = pwm_fault_a_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_DMA_CH5_DONE_IRQ_EN] = dma_ch5_done_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_CODEC_IF_EVENT_IRQ_EN] = codec_if_event_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_CODEC_IF_ERROR_IRQ_EN] = codec_if_error_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_QUAD_ENCODER_IRQ_EN] = quad_encoder_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_PWM_ERROR_IRQ_EN] = pwm_error_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_CAN2_EVENT_IRQ_EN] = can2_event_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_CAN2_RX_READY_IRQ_EN] = can2_rx_ready_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_EXT_PIN4_IRQ_EN] = ext_pin4_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_EXT_PIN3_IRQ_EN] = ext_pin3_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_TIMER9_IRQ_EN] = timer9_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_TIMER8_IRQ_EN] = timer8_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_I2C2_MASTER_IRQ_EN] = i2c2_master_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_I2C2_SLAVE_IRQ_EN] = i2c2_slave_req_i;
      req_words[ieb_pkg::W3][ieb_pkg::POS_TIMER7_IRQ_EN] = timer7_req_i;
   end

   always_comb begin
      logic hit;
      logic mapped;
      logic [ieb_pkg::NWORD-1:0] any_now;
      logic [ieb_pkg::NSTS-1:0] set_v;
      logic [ieb_pkg::NSTS-1:0] clr_v;
      hit = 1'b0;
      mapped = 1'b0;
      any_now = '0;
      set_v = '0;
      clr_v = '0;
      s_next = s_reg;
      // ack only every other cycle, so one held request is taken once
      hit = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      s_next.ack = hit;
      s_next.dat = '0;
      s_next.gated = gbus.gated;
      for (int w = 0; w < ieb_pkg::NWORD; w++) begin
         any_now[w] = |gbus.gated[w];
      end
      s_next.any = any_now;
      set_v[ieb_pkg::NWORD-1:0] = any_now & ~s_reg.any;
      if (hit) begin
         mapped = 1'b1;
         case ({wb_adr_i[7:2], 2'b00})
            ieb_pkg::OFS_EN1: begin
               s_next.dat = {16'h0000, s_reg.en[ieb_pkg::W1]};
               if (wb_we_i) begin
                  s_next.en[ieb_pkg::W1] = ieb_merge(s_reg.en[ieb_pkg::W1], wb_dat_i,
                     wb_sel_i, ieb_pkg::IMPL_MASK[ieb_pkg::W1]);
               end
            end
            ieb_pkg::OFS_EN2: begin
               s_next.dat = {16'h0000, s_reg.en[ieb_pkg::W2]};
               if (wb_we_i) begin
                  s_next.en[ieb_pkg::W2] = ieb_merge(s_reg.en[ieb_pkg::W2], wb_dat_i,
                     wb_sel_i, ieb_pkg::IMPL_MASK[ieb_pkg::W2]);
               end
            end
            ieb_pkg::OFS_EN3: begin
               s_next.dat = {16'h0000, s_reg.en[ieb_pkg::W3]};
               if (wb_we_i) begin
                  s_next.en[ieb_pkg::W3] = ieb_merge(s_reg.en[ieb_pkg::W3], wb_dat_i,
                     wb_sel_i, ieb_pkg::IMPL_MASK[ieb_pkg::W3]);
               end
            end
            ieb_pkg::OFS_STS: begin
               s_next.dat = {28'h0000000, s_reg.sts};
               if (wb_we_i && wb_sel_i[0]) begin
                  clr_v = wb_dat_i[ieb_pkg::NSTS-1:0];
               end
            end
            ieb_pkg::OFS_MSK: begin
               s_next.dat = {28'h0000000, s_reg.msk};
               if (wb_we_i && wb_sel_i[0]) begin
                  s_next.msk = wb_dat_i[ieb_pkg::NSTS-1:0];
               end
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
         // unmapped access still acks, reads zero, and is flagged
         set_v[ieb_pkg::STS_UNMAPPED] = ~mapped;
      end
      // a new event in the clearing cycle survives the clear
      s_next.sts = (s_reg.sts & ~clr_v) | set_v;
      s_next.irq = |(s_next.sts & s_next.msk);
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_reg.en <= {ieb_pkg::EN_RST, ieb_pkg::EN_RST, ieb_pkg::EN_RST};
         s_reg.gated <= '0;
         s_reg.any <= '0;
         s_reg.sts <= ieb_pkg::STS_RST;
         s_reg.msk <= ieb_pkg::MSK_RST;
         s_reg.ack <= 1'b0;
         s_reg.dat <= '0;
         s_reg.irq <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_o = s_reg.dat;
   assign wb_ack_o = s_reg.ack;
   assign irq_o = s_reg.irq;
   assign gated_word_1_o = s_reg.gated[ieb_pkg::W1];
   assign gated_word_2_o = s_reg.gated[ieb_pkg::W2];
   assign gated_word_3_o = s_reg.gated[ieb_pkg::W3];
endmodule
`default_nettype wire

// ==== ieb_props.sv ====
// port assertions for the interrupt enable bank
`timescale 1ns/10ps
`default_nettype none
module ieb_props (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire logic i2c1_slave_req_i,
   input wire logic [15:0] gated_word_1_o,
   input wire logic [15:0] gated_word_2_o,
   input wire logic [15:0] gated_word_3_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   sequence req_new;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ack_answer_a: assert property (req_new |=> ack_pulse)
      else $error("request not answered by one ack");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside an answer");
   rd_unused_a: assert property (wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) == ieb_pkg::OFS_EN1 |-> wb_dat_o[2] == 1'b0)
      else $error("unused enable bit read as one");
   w1_unused_a: assert property ((gated_word_1_o & 16'hfff4) == 16'h0)
      else $error("unused word 1 position passed");
   w2_unused_a: assert property (!gated_word_2_o[13])
      else $error("unused word 2 position passed");
   w3_unused_a: assert property (!gated_word_3_o[14])
      else $error("unused word 3 position passed");
   src_block_a: assert property (!$past(i2c1_slave_req_i) |-> !gated_word_1_o[0])
      else $error("gated bit without request");
   rst_clear_a: assert property ($fell(rst_i) |-> !irq_o && gated_word_3_o == 16'h0)
      else $error("state left after reset");
endmodule
bind ieb_top ieb_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .irq_o(irq_o), .i2c1_slave_req_i(i2c1_slave_req_i),
   .gated_word_1_o(gated_word_1_o), .gated_word_2_o(gated_word_2_o),
   .gated_word_3_o(gated_word_3_o));
`default_nettype wire

// ==== ieb_src_model.sv ====
// request source model in enable word layout
`timescale 1ns/10ps
`default_nettype none
module ieb_src_model (
   input wire logic mclk_i,
   input wire ieb_pkg::ieb_words_t pattern_i,
   output var ieb_pkg::ieb_words_t req_o
);
   // sources move just after the edge, like registered peripheral flags
   always @(posedge mclk_i) begin
      req_o <= pattern_i;
   end
endmodule
`default_nettype wire

// ==== ieb_top_tb.sv ====
// self-checking testbench of the interrupt enable bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module ieb_top_tb;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o;
   logic [7:0] wb_adr_i = 8'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic pin_change_req_i, i2c1_master_req_i, i2c1_slave_req_i, timer6_req_i;
   logic dma_ch4_done_req_i, dma_ch3_done_req_i, can1_event_req_i, can1_rx_ready_req_i;
   logic spi2_event_req_i, spi2_error_req_i, pwm_fault_a_req_i, dma_ch5_done_req_i;
   logic codec_if_event_req_i, codec_if_error_req_i, quad_encoder_req_i, pwm_error_req_i;
   logic can2_event_req_i, can2_rx_ready_req_i, ext_pin4_req_i, ext_pin3_req_i;
   logic timer9_req_i, timer8_req_i, i2c2_master_req_i, i2c2_slave_req_i, timer7_req_i;
   logic [3:0] compare8_5_req_i, capture6_3_req_i;
   logic [15:0] gated_word_1_o, gated_word_2_o, gated_word_3_o;
   logic [47:0] gated_all;
   assign gated_all = {gated_word_3_o, gated_word_2_o, gated_word_1_o};
   ieb_pkg::ieb_words_t pat = '0, req;
   int errors = 0, num_checks = 0, cycles = 0;
   assign {pin_change_req_i, i2c1_master_req_i, i2c1_slave_req_i} =
      {req[0][3], req[0][1:0]};
   assign {timer6_req_i, dma_ch4_done_req_i, compare8_5_req_i, capture6_3_req_i,
      dma_ch3_done_req_i} = {req[1][15:14], req[1][12:4]};
   assign {can1_event_req_i, can1_rx_ready_req_i, spi2_event_req_i,
      spi2_error_req_i} = req[1][3:0];
   assign {pwm_fault_a_req_i, dma_ch5_done_req_i, codec_if_event_req_i, codec_if_error_req_i,
      quad_encoder_req_i, pwm_error_req_i, can2_event_req_i} = {req[2][15], req[2][13:8]};
   assign {can2_rx_ready_req_i, ext_pin4_req_i, ext_pin3_req_i, timer9_req_i, timer8_req_i,
      i2c2_master_req_i, i2c2_slave_req_i, timer7_req_i} = req[2][7:0];
   ieb_top u_dut (.*);
   ieb_src_model u_src (.mclk_i(mclk_i), .pattern_i(pat), .req_o(req));
   initial forever #12.5 mclk_i = ~mclk_i;
   task stop_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         stop_test;
      end
   end
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge mclk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'h3;
      // ack and read data are judged as they stand at the rising edge
      @(posedge mclk_i);
      while (wb_ack_o !== 1'b1) begin
         @(posedge mclk_i);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // model register plus output register: two edges, one spare
   task automatic drive(input ieb_pkg::ieb_words_t p);
      @(posedge mclk_i);
      pat <= p;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask
   task t_regs;
      for (int w = 0; w < 3; w++) begin
         wb(1'b0, 8'(4 * w), 32'h0);
         `CHK(rd, 32'h0)
         wb(1'b1, 8'(4 * w), 32'hffffffff);
         wb(1'b0, 8'(4 * w), 32'h0);
         `CHK(rd, {16'h0, ieb_pkg::IMPL_MASK[w]})
      end
   endtask
   task t_walk;
      for (int w = 0; w < 3; w++) for (int b = 0; b < 16; b++) if (ieb_pkg::IMPL_MASK[w][b]) begin
         drive(48'h1 << (16 * w + b));
         `CHK(gated_all, 48'h1 << (16 * w + b))
      end
   endtask
   task t_block;
      wb(1'b1, ieb_pkg::OFS_EN2, 32'h0);
      wb(1'b1, ieb_pkg::OFS_EN3, 32'h5555);
      drive('1);
      `CHK(gated_word_2_o, 16'h0)
      `CHK(gated_word_3_o, 16'h1555)
      `CHK(gated_word_1_o, 16'h000b)
      drive('0);
   endtask
   task t_irq;
      wb(1'b1, ieb_pkg::OFS_STS, 32'hf);
      wb(1'b1, ieb_pkg::OFS_MSK, 32'h1);
      drive(48'h1);
      `CHK(irq_o, 1'b1)
      wb(1'b1, ieb_pkg::OFS_STS, 32'h1);
      drive(48'h1);
      `CHK(irq_o, 1'b0)
      wb(1'b0, 8'h14, 32'h0);
      `CHK(rd, 32'h0)
      wb(1'b0, ieb_pkg::OFS_STS, 32'h0);
      `CHK(rd, 32'h8)
      `CHK(irq_o, 1'b0)
      wb(1'b1, ieb_pkg::OFS_MSK, 32'h8);
      drive('0);
      `CHK(irq_o, 1'b1)
      wb(1'b1, ieb_pkg::OFS_STS, 32'h8);
      drive('0);
      `CHK(irq_o, 1'b0)
   endtask
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_regs;
      t_walk;
      t_block;
      t_irq;
      stop_test;
   end
endmodule
`default_nettype wire
